/* File: hdl/fdma_defs.vh */
// Register map, field positions and codes of the four-channel DMA controller.
// Assumes an 8-bit register port decoding the low address byte only.
`ifndef FDMA_DEFS_VH
`define FDMA_DEFS_VH
// ****************************************************************
// Register window and byte offsets inside one sub-channel
// ****************************************************************
`define FDMA_WIN_MASK   8'he0
`define FDMA_WIN_BASE   8'h20
`define FDMA_K_MARR     3'h0
`define FDMA_K_MARE     3'h1
`define FDMA_K_MARH     3'h2
`define FDMA_K_MARL     3'h3
`define FDMA_K_COUNT_UPPER_BYTE    3'h4
`define FDMA_K_COUNT_LOWER_BYTE    3'h5
`define FDMA_K_IO_SIDE_ADDRESS     3'h6
`define FDMA_K_DTCR     3'h7
// ****************************************************************
// Reset and fixed values
// ****************************************************************
`define FDMA_DTCR_RST   8'h00
`define FDMA_MARR_RD    8'hff
`define FDMA_IO_HI      16'hffff
`define FDMA_CNT_ONE    16'h0001
`define FDMA_BLK_ONE    8'h01
// ****************************************************************
// Control register bit positions
// ****************************************************************
`define FDMA_B_DTE      7
`define FDMA_B_WORD     6
`define FDMA_B_DEC      5
`define FDMA_B_HOLD     4
`define FDMA_B_AREA     3
`define FDMA_B_BLK      3
`define FDMA_B_SEL_HI   2
`define FDMA_B_SEL_LO   1
// ****************************************************************
// Short mode kinds and start source codes
// ****************************************************************
`define FDMA_SMODE_IO   2'h0
`define FDMA_SMODE_IDLE 2'h1
`define FDMA_SMODE_RPT  2'h2
`define FDMA_DTS_TXE    3'h4
`define FDMA_DTS_RXF    3'h5
`define FDMA_DTS_ACS    3'h4
`define FDMA_DTS_ABU    3'h5
`define FDMA_DTS_EXT    3'h7
`endif

/* File: hdl/fdma_sync.v */
// Three-stage synchroniser for request pins, one lane per bit.
// Assumes inputs asynchronous to clk; output moves when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module fdma_sync #(
  parameter W = 2
) (
  // Clock and reset
  input  wire         clk,
  input  wire         srst,
  // Pins in, clean levels out
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] lvl_out
);
  // ****************************************************************
  // One lane per bit
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : gl
      reg s1_r;  // Only stage two reads this one
      reg s2_r;  // Second stage
      reg s3_r;  // Third stage
      reg lv_r;  // Accepted level
      // Shift and accept only on agreement, which drops one-stage glitches
      always @(posedge clk) begin
        if (srst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          lv_r <= 1'b0;
        end else begin
          s1_r <= pin_in[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lv_r <= s3_r;
          end
        end
      end
      assign lvl_out[g] = lv_r;
    end
  endgenerate
endmodule // fdma_sync
`default_nettype wire

/* File: hdl/fdma_step.v */
// Next memory address after one byte or word moved.
// Assumes a 24-bit flat space; wraps silently at either end.
`timescale 1ns/1ps
`default_nettype none
module fdma_step (
  // Current address and step controls
  input  wire [23:0] addr,
  input  wire        word,
  input  wire        dec,
  input  wire        hold,
  // Stepped address
  output wire [23:0] nxt
);
  // Step of 1 for bytes, 2 for words
  wire [23:0] amt = word ? 24'h000002 : 24'h000001;
  // A held address never moves; otherwise step up or down
  assign nxt = hold ? addr : (dec ? addr - amt : addr + amt);
endmodule // fdma_step
`default_nettype wire

/* File: hdl/fdma_top.v */
// Four-channel DMA controller: register file, request logic and one bus engine.
// Assumes a bus agent that runs each issued transfer and pulses xfer_ack once.
// Functional notes
// - Short mode: 8-bit I/O plus 24-bit memory address
// - Four short channels: I/O, idle or repeat
// - Full mode: two channels, normal or block
// - Byte or word unit over 16 Mbytes
// - I/O mode steps memory by 1 or 2
// - Idle mode keeps memory address fixed
// - Repeat mode reloads address and count, continues
// - Starts from timers, serial, pins or auto
// - Auto-request runs whole count, burst or steal
// - External request moves one unit, or one block in block mode
// - Block mode moves one block per request
// - Source or destination may be fixed block area
// - Request pins trigger channels zero and one
// - One transfer-end output per channel
// - Sub-channel A ignores the request pin
// - Both mode-select bits set gives full mode
// - Repeat upper count reloads from lower byte
// - I/O address upper bits all ones, fixed
// - Requests ignored while transfer enable clear
`include "fdma_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module fdma_top (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // On-chip start sources
  input  wire [3:0]  tmr_irq,
  input  wire        sci_txe,
  input  wire        sci_rxf,
  // Request pins
  input  wire [1:0]  ext_xfer_request,
  // Transfer issue to the bus agent
  output reg         xfer_req,
  output reg  [23:0] xfer_src,
  output reg  [23:0] xfer_dst,
  output reg         xfer_word,
  output reg         xfer_burst,
  input  wire        xfer_ack,
  // Transfer end per channel
  output reg  [1:0]  xfer_end_out_n
);
  // ****************************************************************
  // Engine states
  // ****************************************************************
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_ISSUE = 2'd1;
  localparam [1:0] ST_BUS   = 2'd2;

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Addresses, counts and I/O bytes are left unreset on purpose: software
  // must load them before it sets the enable bit, so a reset value would
  // only cost area and never be used.
  reg  [23:0] mar_r  [0:3];  // Memory addresses, index {channel, sub}
  reg  [23:0] base_r [0:3];  // Last written address, for rewinds
  reg  [15:0] etcr_r [0:3];  // Transfer counts
  reg  [7:0]  io_side_address_r [0:3];  // I/O side low bytes
  reg  [7:0]  dtcr_r [0:3];  // Control
  reg  [1:0]  st_r;          // Engine state
  reg  [1:0]  sel_r;         // Sub-channel being served
  integer     i;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  // Only the A control byte of a channel picks its mode; a write to the B
  // byte never changes how the channel is split.
  wire [1:0] mode_sel_hi = {dtcr_r[2][`FDMA_B_SEL_HI], dtcr_r[0][`FDMA_B_SEL_HI]};
  wire [1:0] mode_sel_lo = {dtcr_r[2][`FDMA_B_SEL_LO], dtcr_r[0][`FDMA_B_SEL_LO]};
  wire [1:0] full = mode_sel_hi & mode_sel_lo;
  wire [3:0] channel_xfer_enable;
  wire [3:0] ready;    // Sub-channel wants the bus
  reg  [3:0] clr_w;    // Request consumed this cycle

  // ****************************************************************
  // Request pins
  // ****************************************************************
  // Pins are asynchronous, so they pass the synchroniser first; only a
  // rising level counts, and a pin held high asks for nothing more.
  wire [1:0] ext_lvl;   // Clean pin levels
  reg  [1:0] ext_d_r;   // Previous level, for edges
  wire [1:0] ext_rise = ext_lvl & ~ext_d_r;

  // One lane per channel pin
  fdma_sync #(
    .W       (2)
  ) u_sync (
    .clk     (clk),
    .srst    (srst),
    .pin_in  (ext_xfer_request),
    .lvl_out (ext_lvl)
  );

  // Edge memory so one pin pulse is one request
  always @(posedge clk) begin
    if (srst) begin
      ext_d_r <= 2'b00;
    end else begin
      ext_d_r <= ext_lvl;
    end
  end

  // ****************************************************************
  // Per sub-channel start logic
  // ****************************************************************
  // Each sub-channel keeps one pending flag. An event that arrives while
  // the flag is already set merges into it, so starts must not come faster
  // than the engine drains them.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gs
      localparam [0:0] IS_B = ((g % 2) != 0);
      wire [2:0] dts  = dtcr_r[g][2:0];
      wire       fm   = full[g / 2];
      wire       blk  = fm & dtcr_r[g][`FDMA_B_BLK];
      wire       auto = fm & ~blk & ((dts == `FDMA_DTS_ACS) | (dts == `FDMA_DTS_ABU));
      reg        trig;
      reg        pend_q;
      // Source select; serial starts only exist in short mode
      always @* begin
        trig = 1'b0;
        if (!dts[2]) begin
          trig = tmr_irq[dts[1:0]] & (~fm | blk);
        end else if (!fm && dts == `FDMA_DTS_TXE) begin
          trig = sci_txe;
        end else if (!fm && dts == `FDMA_DTS_RXF) begin
          trig = sci_rxf;
        end else if (dts == `FDMA_DTS_EXT) begin
          trig = ext_rise[g / 2] & IS_B;
        end
      end
      // New request beats the clear in the same cycle; disabled drops it
      always @(posedge clk) begin
        if (srst) begin
          pend_q <= 1'b0;
        end else begin
          pend_q <= channel_xfer_enable[g] & (trig | (pend_q & ~clr_w[g]));
        end
      end
      assign channel_xfer_enable[g] = dtcr_r[g][`FDMA_B_DTE];
      // Full channel lives on its B half; auto needs no external event
      assign ready[g] = channel_xfer_enable[g] &
                        (fm ? (IS_B & (pend_q | auto)) : pend_q);
    end
  endgenerate

  // ****************************************************************
  // Served sub-channel decode
  // ****************************************************************
  // All of this follows sel_r, frozen from pick to ack, so the values seen
  // at issue and at ack always belong to the same sub-channel.
  wire        ch  = sel_r[1];
  wire        fm  = full[ch];
  wire [1:0]  ia  = fm ? {ch, 1'b0} : sel_r;  // Source side in full mode
  wire [1:0]  ib  = {ch, 1'b1};               // Destination side in full mode
  wire [7:0]  ca  = dtcr_r[ia];
  wire [7:0]  cb  = dtcr_r[ib];
  wire [1:0]  smode = ca[`FDMA_B_HOLD:`FDMA_B_AREA];
  wire        blk = fm & cb[`FDMA_B_BLK];
  wire        rpt = ~fm & (smode == `FDMA_SMODE_RPT);
  wire        rx  = ~fm & (ca[2:0] == `FDMA_DTS_RXF);
  wire [7:0]  count_upper_byte = etcr_r[ia][15:8];
  wire [7:0]  count_lower_byte = etcr_r[ia][7:0];
  wire        hi_one = (count_upper_byte == `FDMA_BLK_ONE);
  wire        blk_end = blk & hi_one;
  wire [23:0] io_side_address = {`FDMA_IO_HI, io_side_address_r[ia]};
  wire [23:0] a_nxt;
  wire [23:0] b_nxt;
  wire        last = blk ? (hi_one & (etcr_r[ib] == `FDMA_CNT_ONE)) :
                     rpt ? hi_one : (etcr_r[ia] == `FDMA_CNT_ONE);
  wire        done = (st_r == ST_BUS) & xfer_ack;

  // Memory side steps; idle mode and held full sides stay put
  fdma_step u_step_a (
    .addr (mar_r[ia]),
    .word (ca[`FDMA_B_WORD]),
    .dec  (ca[`FDMA_B_DEC]),
    .hold (fm ? ca[`FDMA_B_HOLD] : (smode == `FDMA_SMODE_IDLE)),
    .nxt  (a_nxt)
  );

  // Both sides step by the A word bit, so source and destination steps are the same size
  fdma_step u_step_b (
    .addr (mar_r[ib]),
    .word (ca[`FDMA_B_WORD]),
    .dec  (cb[`FDMA_B_DEC]),
    .hold (cb[`FDMA_B_HOLD]),
    .nxt  (b_nxt)
  );

  // Block mode keeps its request across the units of one block and drops it
  // only with the last unit, so one event moves a whole block.
  // Consume requests: one unit per request, one block per block request
  always @* begin
    clr_w = 4'b0000;
    if (done && (!blk || blk_end)) begin
      clr_w[fm ? ib : sel_r] = 1'b1;
    end
  end

  // ****************************************************************
  // Engine and register file
  // ****************************************************************
  // One transfer is outstanding at a time; the idle state between two
  // transfers lets a lower sub-channel win the next pick.
  // Lowest index wins; the served channel is frozen until its ack
  always @(posedge clk) begin
    if (srst) begin
      st_r           <= ST_IDLE;
      sel_r          <= 2'b00;
      xfer_req       <= 1'b0;
      xfer_src       <= 24'h000000;
      xfer_dst       <= 24'h000000;
      xfer_word      <= 1'b0;
      xfer_burst     <= 1'b0;
      xfer_end_out_n <= 2'b11;
      reg_rdata      <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        dtcr_r[i] <= `FDMA_DTCR_RST;
      end
    end else begin
      case (st_r)
        // Pick a ready sub-channel
        // Fixed priority: sub-channel 0 first, 3 last
        ST_IDLE: begin
          if (|ready) begin
            sel_r <= ready[0] ? 2'd0 : ready[1] ? 2'd1 : ready[2] ? 2'd2 : 2'd3;
            st_r  <= ST_ISSUE;
          end
        end
        // Present addresses from flops; in short mode direction follows the start source
        ST_ISSUE: begin
          xfer_req   <= 1'b1;
          // Short-mode serial receive makes the I/O byte the source; other short starts write to it
          xfer_src   <= (fm || !rx) ? mar_r[ia] : io_side_address;
          xfer_dst   <= fm ? mar_r[ib] : (rx ? mar_r[ia] : io_side_address);
          xfer_word  <= ca[`FDMA_B_WORD];
          xfer_burst <= fm & ~blk & (cb[2:0] == `FDMA_DTS_ABU);
          xfer_end_out_n[ch] <= ~last;
          st_r <= ST_BUS;
        end
        // Wait for the bus agent, then update counts and addresses
        ST_BUS: begin
          if (xfer_ack) begin
            xfer_req       <= 1'b0;
            xfer_burst     <= 1'b0;
            xfer_end_out_n <= 2'b11;
            st_r           <= ST_IDLE;
            mar_r[ia]      <= a_nxt;
            if (fm) begin
              mar_r[ib] <= b_nxt;
            end
            // Repeat: the lower byte keeps the initial count for every reload
            if (rpt) begin
              if (hi_one) begin
                etcr_r[ia][15:8] <= count_lower_byte;
                mar_r[ia]        <= base_r[ia];
              end else begin
                etcr_r[ia][15:8] <= count_upper_byte - 8'h01;
              end
            end else if (blk) begin
              // Block end: reload size, count blocks, rewind the fixed side
              if (hi_one) begin
                etcr_r[ia][15:8] <= count_lower_byte;
                etcr_r[ib]       <= etcr_r[ib] - 16'h0001;
                if (ca[`FDMA_B_AREA]) begin
                  mar_r[ib] <= base_r[ib];
                end else begin
                  mar_r[ia] <= base_r[ia];
                end
                if (etcr_r[ib] == `FDMA_CNT_ONE) begin
                  dtcr_r[ib][`FDMA_B_DTE] <= 1'b0;
                end
              end else begin
                etcr_r[ia][15:8] <= count_upper_byte - 8'h01;
              end
            end else begin
              // Zero count means 65,536 through natural wrap
              etcr_r[ia] <= etcr_r[ia] - 16'h0001;
              if (etcr_r[ia] == `FDMA_CNT_ONE) begin
                dtcr_r[fm ? ib : ia][`FDMA_B_DTE] <= 1'b0;
              end
            end
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
      // Software writes land after the engine so they take effect
      // A written enable bit therefore beats the hardware clear at count end
      if (reg_wr && ((reg_addr & `FDMA_WIN_MASK) == `FDMA_WIN_BASE)) begin
        case (reg_addr[2:0])
          `FDMA_K_MARE: begin
            mar_r[reg_addr[4:3]][23:16]  <= reg_wdata;
            base_r[reg_addr[4:3]][23:16] <= reg_wdata;
          end
          `FDMA_K_MARH: begin
            mar_r[reg_addr[4:3]][15:8]  <= reg_wdata;
            base_r[reg_addr[4:3]][15:8] <= reg_wdata;
          end
          `FDMA_K_MARL: begin
            mar_r[reg_addr[4:3]][7:0]  <= reg_wdata;
            base_r[reg_addr[4:3]][7:0] <= reg_wdata;
          end
          `FDMA_K_COUNT_UPPER_BYTE: etcr_r[reg_addr[4:3]][15:8] <= reg_wdata;
          `FDMA_K_COUNT_LOWER_BYTE: etcr_r[reg_addr[4:3]][7:0]  <= reg_wdata;
          `FDMA_K_IO_SIDE_ADDRESS:  io_side_address_r[reg_addr[4:3]]       <= reg_wdata;
          `FDMA_K_DTCR:  dtcr_r[reg_addr[4:3]]       <= reg_wdata;
          default: begin
            // Top address byte is read-only
          end
        endcase
      end
      // Read data stand for one cycle after the strobe
      if (reg_rd && ((reg_addr & `FDMA_WIN_MASK) == `FDMA_WIN_BASE)) begin
        case (reg_addr[2:0])
          // Top address byte has no storage and always reads as ones
          `FDMA_K_MARR:  reg_rdata <= `FDMA_MARR_RD;
          `FDMA_K_MARE:  reg_rdata <= mar_r[reg_addr[4:3]][23:16];
          `FDMA_K_MARH:  reg_rdata <= mar_r[reg_addr[4:3]][15:8];
          `FDMA_K_MARL:  reg_rdata <= mar_r[reg_addr[4:3]][7:0];
          `FDMA_K_COUNT_UPPER_BYTE: reg_rdata <= etcr_r[reg_addr[4:3]][15:8];
          `FDMA_K_COUNT_LOWER_BYTE: reg_rdata <= etcr_r[reg_addr[4:3]][7:0];
          `FDMA_K_IO_SIDE_ADDRESS:  reg_rdata <= io_side_address_r[reg_addr[4:3]];
          default:       reg_rdata <= dtcr_r[reg_addr[4:3]];
        endcase
      end else begin
        // Unmapped or no read: zero
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule // fdma_top
`default_nettype wire

/* File: tb/fdma_monitor.sv */
// Checker on the ports of the DMA controller top.
// Assumes one clock domain, srst synchronous active high.
`include "fdma_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module fdma_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Transfer port
  input wire logic        xfer_req,
  input wire logic [23:0] xfer_src,
  input wire logic [23:0] xfer_dst,
  input wire logic        xfer_word,
  input wire logic        xfer_ack,
  input wire logic [1:0]  xfer_end_out_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Address lies inside the register window
  wire in_win = (reg_addr & `FDMA_WIN_MASK) == `FDMA_WIN_BASE;
  // Transfer waiting for the agent, and transfer being completed
  sequence s_wait; xfer_req && !xfer_ack; endsequence
  sequence s_done; xfer_req && xfer_ack; endsequence
  xfer_hold_a: assert property (s_wait |=> xfer_req && $stable(xfer_src)
    && $stable(xfer_dst) && $stable(xfer_word)) else $error("transfer changed before ack");
  end_hold_a: assert property (s_wait |=> $stable(xfer_end_out_n))
    else $error("end marker changed before ack");
  xfer_drop_a: assert property (s_done |=> ##[0:1] !xfer_req)
    else $error("request stayed after ack");
  end_in_xfer_a: assert property (xfer_end_out_n != 2'b11 |-> xfer_req)
    else $error("end marker outside a transfer");
  one_end_a: assert property (xfer_end_out_n != 2'b00)
    else $error("both end markers low");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  top_byte_a: assert property (reg_rd && in_win && reg_addr[2:0] == `FDMA_K_MARR
    |=> reg_rdata == `FDMA_MARR_RD) else $error("top address byte not all ones");
  unmapped_a: assert property (reg_rd && !in_win |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // fdma_monitor
bind fdma_top fdma_monitor u_mon (.clk(clk), .srst(srst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_req(xfer_req), .xfer_src(xfer_src),
  .xfer_dst(xfer_dst), .xfer_word(xfer_word), .xfer_ack(xfer_ack),
  .xfer_end_out_n(xfer_end_out_n));
`default_nettype wire

/* File: tb/fdma_agent.sv */
// Bus agent model: runs each issued transfer and acks once.
// Assumes xfer_req holds until after the ack; delay set by the bench.
`timescale 1ns/1ps
`default_nettype none
module fdma_agent (
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // Wait states before ack, zero answers promptly
  input wire logic [3:0] dly,
  // Transfer handshake
  input wire logic       xfer_req,
  output logic           xfer_ack
);
  logic [3:0] cnt_r;  // Wait states spent
  logic       busy_r; // Ack given, request not yet dropped
  // One ack per request; busy blocks a second ack while req drops
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r    <= 4'h0;
      busy_r   <= 1'b0;
      xfer_ack <= 1'b0;
    end else begin
      xfer_ack <= 1'b0;
      if (!xfer_req) begin
        busy_r <= 1'b0;
      end else if (!busy_r && cnt_r == dly) begin
        xfer_ack <= 1'b1;
        busy_r   <= 1'b1;
        cnt_r    <= 4'h0;
      end else if (!busy_r) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule // fdma_agent
`default_nettype wire

/* File: tb/fdma_top_tb_top.sv */
// Bench for the DMA controller: register tasks, start events, pins.
// Assumes fdma_agent answers transfers and fdma_monitor is bound.
`timescale 1ns/1ps
`default_nettype none
module fdma_top_tb_top;
  logic        clk, srst, reg_wr, reg_rd, sci_txe, sci_rxf, xfer_ack;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  tmr_irq, ag_dly;
  logic [1:0]  ext_xfer_request, xfer_end_out_n;
  logic        xfer_req, xfer_word, xfer_burst;
  logic [23:0] xfer_src, xfer_dst;
  int          fail_count, n_compared, cyc;
  fdma_top uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tmr_irq(tmr_irq),
    .sci_txe(sci_txe), .sci_rxf(sci_rxf), .ext_xfer_request(ext_xfer_request),
    .xfer_req(xfer_req), .xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_word(xfer_word),
    .xfer_burst(xfer_burst), .xfer_ack(xfer_ack), .xfer_end_out_n(xfer_end_out_n));
  fdma_agent u_ag (.clk(clk), .srst(srst), .dly(ag_dly), .xfer_req(xfer_req),
    .xfer_ack(xfer_ack));
  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // A hang is cut short well past the longest expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done;
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One-cycle strobes; a gap cycle follows each
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk({16'h0000, reg_rdata}, {16'h0000, e});
  endtask
  // Sub-channel set-up: memory address, count, I/O byte, control last
  task automatic prog(input logic [7:0] b, input logic [23:0] m, input logic [15:0] c,
                      input logic [7:0] io, input logic [7:0] ct);
    wr(b + 8'h01, m[23:16]);
    wr(b + 8'h02, m[15:8]);
    wr(b + 8'h03, m[7:0]);
    wr(b + 8'h04, c[15:8]);
    wr(b + 8'h05, c[7:0]);
    wr(b + 8'h06, io);
    wr(b + 8'h07, ct);
  endtask
  // Start event pulse: {rx, tx, timers}
  task automatic evt(input logic [5:0] v);
    @(posedge clk) {sci_rxf, sci_txe, tmr_irq} <= v;
    @(posedge clk) {sci_rxf, sci_txe, tmr_irq} <= 6'h00;
  endtask
  // Wait for one transfer, compare what it carries, wait for its end
  task automatic x(input logic [23:0] s, input logic [23:0] d, input logic w,
                   input logic bu, input logic [1:0] e);
    int n;
    n = 0;
    while (xfer_req !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    chk(xfer_src, s);
    chk(xfer_dst, d);
    chk({xfer_burst, xfer_word}, {bu, w});
    chk(xfer_end_out_n, e);
    while (xfer_req === 1'b1 && n < 120) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  // No transfer may start for twenty cycles
  task automatic quiet;
    repeat (20) begin
      @(posedge clk);
      #1 chk(xfer_req, 1'b0);
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {srst, reg_wr, reg_rd, sci_txe, sci_rxf} = 5'h10;
    {reg_addr, reg_wdata, tmr_irq, ag_dly, ext_xfer_request} = 26'h0;
    {fail_count, n_compared, cyc} = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(8'h27, 8'h00);
    rd(8'h20, 8'hff);
    rd(8'h10, 8'h00);
    // I/O mode, byte, increment, timer 0, two transfers
    prog(8'h20, 24'h123456, 16'h0002, 8'h40, 8'h80);
    evt(6'h01);
    x(24'h123456, 24'hffff40, 1'b0, 1'b0, 2'b11);
    evt(6'h01);
    x(24'h123457, 24'hffff40, 1'b0, 1'b0, 2'b10);
    rd(8'h27, 8'h00);
    evt(6'h01);
    quiet;
    // Idle mode, word, serial receive puts I/O side first
    prog(8'h38, 24'h001000, 16'h0001, 8'h80, 8'hed);
    evt(6'h20);
    x(24'hffff80, 24'h001000, 1'b1, 1'b0, 2'b01);
    rd(8'h3a, 8'h10);
    // Repeat mode with a slow agent, count of two
    ag_dly <= 4'h6;
    prog(8'h30, 24'h200000, 16'h0202, 8'h10, 8'h91);
    evt(6'h02);
    x(24'h200000, 24'hffff10, 1'b0, 1'b0, 2'b11);
    evt(6'h02);
    x(24'h200001, 24'hffff10, 1'b0, 1'b0, 2'b01);
    evt(6'h02);
    x(24'h200000, 24'hffff10, 1'b0, 1'b0, 2'b11);
    rd(8'h34, 8'h01);
    rd(8'h37, 8'h91);
    // Pin ignored by short-mode sub-channel A (timer 3), taken by B
    prog(8'h20, 24'h000100, 16'h0001, 8'h22, 8'h83);
    @(posedge clk) ext_xfer_request <= 2'b01;
    quiet;
    @(posedge clk) ext_xfer_request <= 2'b00;
    prog(8'h28, 24'h000100, 16'h0001, 8'h22, 8'h87);
    @(posedge clk) ext_xfer_request <= 2'b01;
    x(24'h000100, 24'hffff22, 1'b0, 1'b0, 2'b10);
    // Full mode, auto-request burst, two transfers back to back
    ag_dly <= 4'h0;
    prog(8'h20, 24'h300000, 16'h0002, 8'h00, 8'h06);
    prog(8'h28, 24'h400000, 16'h0000, 8'h00, 8'h85);
    x(24'h300000, 24'h400000, 1'b0, 1'b1, 2'b11);
    x(24'h300001, 24'h400001, 1'b0, 1'b1, 2'b10);
    // Full mode block transfer on timer 0: two blocks of two, fixed destination
    prog(8'h20, 24'h500000, 16'h0202, 8'h00, 8'h0e);
    prog(8'h28, 24'h600000, 16'h0002, 8'h00, 8'h88);
    evt(6'h01);
    x(24'h500000, 24'h600000, 1'b0, 1'b0, 2'b11);
    x(24'h500001, 24'h600001, 1'b0, 1'b0, 2'b11);
    quiet;
    evt(6'h01);
    x(24'h500002, 24'h600000, 1'b0, 1'b0, 2'b11);
    x(24'h500003, 24'h600001, 1'b0, 1'b0, 2'b10);
    rd(8'h2f, 8'h08);
    test_done;
  end
endmodule // fdma_top_tb_top
`default_nettype wire
